// *** cmp_pkg.sv ***
// Constants and types shared by the comparator control block.
// Assumes one 50 MHz clock and an Avalon-MM master with 32-bit data.
package cmp_pkg;
  // ---------------------------------------------------------------
  // Register map (word byte addresses)
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL0_C1   = 5'h00;
  localparam logic [4:0] OFS_CTRL1_C1   = 5'h04;
  localparam logic [4:0] OFS_CTRL0_C2   = 5'h08;
  localparam logic [4:0] OFS_CTRL1_C2   = 5'h0c;
  localparam logic [4:0] OFS_MIRROR     = 5'h10;
  localparam logic [4:0] OFS_FLAGS      = 5'h14;
  localparam logic [4:0] OFS_PORT       = 5'h18;
  localparam logic [4:0] OFS_ANALOG_SELECT_REG      = 5'h1c;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int B_ENABLE   = 7;
  localparam int B_RESULT   = 6;
  localparam int B_INVERT   = 4;
  localparam int B_HOLD     = 3;
  localparam int B_SPEED    = 2;
  localparam int B_HYST     = 1;
  localparam int B_SYNC     = 0;
  localparam int B_RISE_EN  = 7;
  localparam int B_FALL_EN  = 6;
  localparam int B_POS_LO   = 3;
  localparam int B_NEG_LO   = 0;
  // Writable bits of control 0 (result and bit 5 are not)
  localparam logic [7:0] CTRL0_WMASK = 8'h9f;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL0_RST = 8'h04;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] ANALOG_SELECT_REG_RST = 8'hff;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ   = 50;
  localparam int HOLD_NS   = 20;
  localparam int HOLD_RAW  = (HOLD_NS * CLK_MHZ) / 1000;
  localparam int HOLD_CYC  = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
  // ---------------------------------------------------------------
  // Per-comparator analog steering carried to the analog macro
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       connect;
    logic [2:0] pos_input_sel;
    logic [2:0] neg_input_sel;
    logic       speed_select;
    logic       hysteresis_en;
  } analog_ctl_t;
endpackage

// *** cmp_ctrl.sv ***
// Digital control for a pair of analog comparators with an Avalon-MM slave.
// Assumes raw comparator results and timer clocks are asynchronous levels.
//
// Added by the designer: the register addresses and the Avalon-MM register port.
module cmp_ctrl
  import cmp_pkg::*;
#(
  parameter int NUM_CMP = 2
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic [4:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic [NUM_CMP-1:0]    cmp_raw,
  input  wire logic                  tmr_src_clk,
  input  wire logic                  tmr_pre_clk,
  input  wire logic                  tmr_prescale_en,
  input  wire logic [7:0]            pin_level,
  output logic      [NUM_CMP-1:0]    gate_out,
  output logic                       gate_timer_tick,
  output logic      [NUM_CMP-1:0]    cmp_irq_flag,
  output analog_ctl_t [NUM_CMP-1:0]  analog_ctl
);
  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (NUM_CMP != 2) begin : g_bad_count
    $error("cmp_ctrl serves exactly two comparators");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_CMP-1:0][7:0] ctrl0;
    logic [NUM_CMP-1:0][7:0] ctrl1;
    logic [7:0]              analog_select_reg;
    logic [NUM_CMP-1:0]      raw_s1;
    logic [NUM_CMP-1:0]      raw_s2;
    logic [NUM_CMP-1:0]      pol_q;
    logic [NUM_CMP-1:0]      result;
    logic [NUM_CMP-1:0][3:0] hold_cnt;
    logic [NUM_CMP-1:0]      sync_lat;
    logic [NUM_CMP-1:0]      flag;
    logic                    tclk_s1;
    logic                    tclk_s2;
    logic                    tclk_s3;
    logic                    wait_q;
    logic [31:0]             rdata;
    logic [NUM_CMP-1:0]      gate;
    logic                    tick;
    analog_ctl_t [NUM_CMP-1:0] actl;
  } state_t;

  state_t s_q;
  state_t s_d;

  localparam logic [3:0] HOLD_LOAD = 4'(HOLD_CYC);

  // Decodes the control word index for a comparator, used by read and write
  function automatic logic [4:0] ctrl_ofs(input int idx, input bit second);
    logic [4:0] base;
    base = (idx == 0) ? OFS_CTRL0_C1 : OFS_CTRL0_C2;
    return second ? (base + 5'h04) : base;
  endfunction

  // Merge byte lane 0 into an 8-bit register
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [7:0] mask);
    return avs_byteenable[0] ? ((old & ~mask) | (avs_writedata[7:0] & mask)) : old;
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  logic                    req;
  logic                    wr_now;
  logic                    tclk_fall;
  logic                    tclk_rise;
  logic [NUM_CMP-1:0]      eff;
  logic [NUM_CMP-1:0]      rise;
  logic [NUM_CMP-1:0]      fall;
  logic [NUM_CMP-1:0]      clr;

  always_comb begin
    s_d       = s_q;
    req       = avs_read | avs_write;
    wr_now    = avs_write & ~s_q.wait_q;
    tclk_fall = s_q.tclk_s3 & ~s_q.tclk_s2;
    tclk_rise = ~s_q.tclk_s3 & s_q.tclk_s2;
    eff       = '0;
    rise      = '0;
    fall      = '0;
    clr       = '0;

    // Prescaled clock is chosen ahead of the synchroniser
    s_d.tclk_s1 = tmr_prescale_en ? tmr_pre_clk : tmr_src_clk;
    s_d.tclk_s2 = s_q.tclk_s1;
    s_d.tclk_s3 = s_q.tclk_s2;
    s_d.tick    = tclk_rise;

    s_d.raw_s1 = cmp_raw;
    s_d.raw_s2 = s_q.raw_s1;

    // Register writes take effect at the edge waitrequest is seen low
    if (wr_now) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        if (avs_address == ctrl_ofs(i, 1'b0)) begin
          s_d.ctrl0[i] = lane0(s_q.ctrl0[i], CTRL0_WMASK);
        end
        if (avs_address == ctrl_ofs(i, 1'b1)) begin
          s_d.ctrl1[i] = lane0(s_q.ctrl1[i], 8'hff);
        end
      end
      if (avs_address == OFS_ANALOG_SELECT_REG) begin
        s_d.analog_select_reg = lane0(s_q.analog_select_reg, 8'hff);
      end
      if (avs_address == OFS_FLAGS && avs_byteenable[0]) begin
        clr = avs_writedata[NUM_CMP-1:0];
      end
    end

    for (int i = 0; i < NUM_CMP; i++) begin
      // A disabled comparator reads low before the polarity stage
      eff[i] = (s_q.ctrl0[i][B_ENABLE] & s_q.raw_s2[i]) ^ s_q.ctrl0[i][B_INVERT];
      s_d.pol_q[i] = eff[i];
      // Any change while the hold runs would be a reversal, so it is held off when the hold bit (B_HOLD) is set
      if (s_q.hold_cnt[i] != 4'h0) begin
        s_d.hold_cnt[i] = s_q.hold_cnt[i] - 4'h1;
      end
      if (s_q.pol_q[i] != s_q.result[i] &&
          !(s_q.ctrl0[i][B_HOLD] && s_q.hold_cnt[i] != 4'h0)) begin
        s_d.result[i]   = s_q.pol_q[i];
        s_d.hold_cnt[i] = HOLD_LOAD;
      end
      rise[i] = ~s_q.result[i] & s_d.result[i];
      fall[i] =  s_q.result[i] & ~s_d.result[i];
      // Set wins over a clear landing in the same cycle
      s_d.flag[i] = (s_q.flag[i] & ~clr[i]) |
                    (rise[i] & s_q.ctrl1[i][B_RISE_EN]) |
                    (fall[i] & s_q.ctrl1[i][B_FALL_EN]);
      if (tclk_fall) begin
        s_d.sync_lat[i] = s_q.result[i];
      end
      s_d.gate[i] = s_q.ctrl0[i][B_SYNC] ? s_q.sync_lat[i] : s_q.result[i];
      s_d.actl[i].connect       = s_q.ctrl0[i][B_ENABLE];
      s_d.actl[i].pos_input_sel = s_q.ctrl1[i][B_POS_LO +: 3];
      s_d.actl[i].neg_input_sel = s_q.ctrl1[i][B_NEG_LO +: 3];
      s_d.actl[i].speed_select  = s_q.ctrl0[i][B_SPEED];
      s_d.actl[i].hysteresis_en = s_q.ctrl0[i][B_HYST];
    end

    // Bus handshake: one wait cycle, then a single-cycle acknowledge
    if (req && s_q.wait_q) begin
      s_d.wait_q = 1'b0;
      s_d.rdata  = 32'h0000_0000;
      for (int i = 0; i < NUM_CMP; i++) begin
        if (avs_address == ctrl_ofs(i, 1'b0)) begin
          s_d.rdata[7:0] = {s_q.ctrl0[i][7], s_q.result[i], 1'b0,
                            s_q.ctrl0[i][4:0]};
        end
        if (avs_address == ctrl_ofs(i, 1'b1)) begin
          s_d.rdata[7:0] = s_q.ctrl1[i];
        end
      end
      case (avs_address)
        OFS_MIRROR: s_d.rdata[NUM_CMP-1:0] = s_q.result;
        OFS_FLAGS:  s_d.rdata[NUM_CMP-1:0] = s_q.flag;
        OFS_PORT:   s_d.rdata[7:0] = pin_level & ~s_q.analog_select_reg;
        OFS_ANALOG_SELECT_REG:  s_d.rdata[7:0] = s_q.analog_select_reg;
        default:    s_d.rdata[31:8] = 24'h00_0000;
      endcase
    end else begin
      s_d.wait_q = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q          <= '0;
      s_q.ctrl0    <= {NUM_CMP{CTRL0_RST}};
      s_q.ctrl1    <= {NUM_CMP{CTRL1_RST}};
      s_q.analog_select_reg    <= ANALOG_SELECT_REG_RST;
      s_q.wait_q   <= 1'b1;
      // Timer clock chain keeps shifting so no false edge follows reset
      s_q.tclk_s1  <= s_d.tclk_s1;
      s_q.tclk_s2  <= s_d.tclk_s2;
      s_q.tclk_s3  <= s_d.tclk_s3;
      for (int i = 0; i < NUM_CMP; i++) begin
        s_q.actl[i].speed_select <= CTRL0_RST[B_SPEED];
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = s_q.wait_q;
  assign gate_out        = s_q.gate;
  assign gate_timer_tick = s_q.tick;
  assign cmp_irq_flag    = s_q.flag;
  assign analog_ctl      = s_q.actl;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_sync_latch;
    (s_q.tclk_s3 && !s_q.tclk_s2) |=> (s_q.sync_lat[0] == $past(s_q.result[0]));
  endproperty
  a_sync_latch: assert property (p_sync_latch) else $error("sync latch missed fall");

  property p_latch_stable;
    !(s_q.tclk_s3 && !s_q.tclk_s2) |=> $stable(s_q.sync_lat);
  endproperty
  a_latch_stable: assert property (p_latch_stable) else $error("latch moved off fall");

  property p_tick;
    (!s_q.tclk_s3 && s_q.tclk_s2) |=> gate_timer_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("timer tick missing");

  property p_rise_flag;
    (!s_q.result[0] && s_d.result[0] && s_q.ctrl1[0][B_RISE_EN]) |=> cmp_irq_flag[0];
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rising edge lost");

  property p_set_wins;
    (wr_now && avs_address == OFS_FLAGS && avs_byteenable[0] && avs_writedata[1]
     && s_q.result[1] != s_d.result[1] && s_q.ctrl1[1][B_RISE_EN]
     && s_q.ctrl1[1][B_FALL_EN]) |=> cmp_irq_flag[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new edge");

  property p_disconnect;
    !s_q.ctrl0[0][B_ENABLE] |=> !analog_ctl[0].connect;
  endproperty
  a_disconnect: assert property (p_disconnect) else $error("inputs left connected");

  property p_hold;
    (s_q.ctrl0[0][B_HOLD] && $changed(s_q.result[0]) && $stable(s_q.ctrl0[0]))
      |-> ##1 $stable(s_q.result[0]) [*1];
  endproperty
  a_hold: assert property (p_hold) else $error("reversal inside hold time");

  property p_port_mask;
    (avs_read && avs_address == OFS_PORT && s_q.wait_q)
      |=> ((avs_readdata[7:0] & $past(s_q.analog_select_reg)) == 8'h00);
  endproperty
  a_port_mask: assert property (p_port_mask) else $error("analog pin read nonzero");

  property p_gate_async;
    !s_q.ctrl0[0][B_SYNC] |=> gate_out[0] == $past(s_q.result[0]);
  endproperty
  a_gate_async: assert property (p_gate_async) else $error("gate not following result");

  property p_ack_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("acknowledge stretched");

  property p_pre_clk;
    tmr_prescale_en |=> (s_q.tclk_s1 == $past(tmr_pre_clk));
  endproperty
  a_pre_clk: assert property (p_pre_clk) else $error("prescaled clock unused");

  property p_src_clk;
    !tmr_prescale_en |=> (s_q.tclk_s1 == $past(tmr_src_clk));
  endproperty
  a_src_clk: assert property (p_src_clk) else $error("source clock unused");

  property p_tick_only;
    !tclk_rise |=> !gate_timer_tick;
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("tick off rising edge");

  property p_mirror_top;
    (avs_read && s_q.wait_q && avs_address == OFS_MIRROR)
      |=> (avs_readdata[31:NUM_CMP] == '0);
  endproperty
  a_mirror_top: assert property (p_mirror_top) else $error("mirror upper bits set");

  // ---------------------------------------------------------------
  // Per-comparator checks
  // ---------------------------------------------------------------
  for (genvar j = 0; j < NUM_CMP; j++) begin : g_cmp_chk
    property p_fall_flag;
      (s_q.result[j] && !s_d.result[j] && s_q.ctrl1[j][B_FALL_EN]) |=> cmp_irq_flag[j];
    endproperty
    a_fall_flag: assert property (p_fall_flag) else $error("falling edge lost");

    property p_flag_sticky;
      (cmp_irq_flag[j] && !clr[j]) |=> cmp_irq_flag[j];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

    property p_clear_alone;
      (clr[j] && !(rise[j] && s_q.ctrl1[j][B_RISE_EN])
       && !(fall[j] && s_q.ctrl1[j][B_FALL_EN])) |=> !cmp_irq_flag[j];
    endproperty
    a_clear_alone: assert property (p_clear_alone) else $error("flag survived clear");

    property p_set_first;
      (clr[j] && ((rise[j] && s_q.ctrl1[j][B_RISE_EN])
       || (fall[j] && s_q.ctrl1[j][B_FALL_EN]))) |=> cmp_irq_flag[j];
    endproperty
    a_set_first: assert property (p_set_first) else $error("clear beat an edge");

    property p_no_false_set;
      (!cmp_irq_flag[j] && !(rise[j] && s_q.ctrl1[j][B_RISE_EN])
       && !(fall[j] && s_q.ctrl1[j][B_FALL_EN])) |=> !cmp_irq_flag[j];
    endproperty
    a_no_false_set: assert property (p_no_false_set) else $error("flag set unasked");

    property p_off_level;
      !s_q.ctrl0[j][B_ENABLE] |=> (s_q.pol_q[j] == $past(s_q.ctrl0[j][B_INVERT]));
    endproperty
    a_off_level: assert property (p_off_level) else $error("disabled level wrong");

    property p_on_level;
      s_q.ctrl0[j][B_ENABLE]
        |=> (s_q.pol_q[j] == ($past(s_q.raw_s2[j]) ^ $past(s_q.ctrl0[j][B_INVERT])));
    endproperty
    a_on_level: assert property (p_on_level) else $error("polarity wrong");

    property p_filter_off;
      (!s_q.ctrl0[j][B_HOLD] && (s_q.pol_q[j] != s_q.result[j]))
        |=> (s_q.result[j] == $past(s_q.pol_q[j]));
    endproperty
    a_filter_off: assert property (p_filter_off) else $error("change lost");

    property p_read_status;
      (avs_read && s_q.wait_q && avs_address == ctrl_ofs(j, 1'b0))
        |=> (avs_readdata[B_RESULT] == $past(s_q.result[j]))
            && (avs_readdata[B_ENABLE] == $past(s_q.ctrl0[j][B_ENABLE]));
    endproperty
    a_read_status: assert property (p_read_status) else $error("bad status");

    property p_mirror_bit;
      (avs_read && s_q.wait_q && avs_address == OFS_MIRROR)
        |=> (avs_readdata[j] == $past(s_q.result[j]));
    endproperty
    a_mirror_bit: assert property (p_mirror_bit) else $error("mirror bit wrong");

    property p_connect_on;
      s_q.ctrl0[j][B_ENABLE] |=> analog_ctl[j].connect;
    endproperty
    a_connect_on: assert property (p_connect_on) else $error("inputs not connected");

    property p_pos_route;
      1'b1 |=> (analog_ctl[j].pos_input_sel == $past(s_q.ctrl1[j][B_POS_LO +: 3]));
    endproperty
    a_pos_route: assert property (p_pos_route) else $error("positive select lost");

    property p_neg_route;
      1'b1 |=> (analog_ctl[j].neg_input_sel == $past(s_q.ctrl1[j][B_NEG_LO +: 3]));
    endproperty
    a_neg_route: assert property (p_neg_route) else $error("negative select lost");

    property p_speed_route;
      1'b1 |=> (analog_ctl[j].speed_select == $past(s_q.ctrl0[j][B_SPEED]));
    endproperty
    a_speed_route: assert property (p_speed_route) else $error("speed select lost");

    property p_hyst_route;
      1'b1 |=> (analog_ctl[j].hysteresis_en == $past(s_q.ctrl0[j][B_HYST]));
    endproperty
    a_hyst_route: assert property (p_hyst_route) else $error("hysteresis lost");

    property p_gate_sync;
      s_q.ctrl0[j][B_SYNC] |=> (gate_out[j] == $past(s_q.sync_lat[j]));
    endproperty
    a_gate_sync: assert property (p_gate_sync) else $error("gate not from latch");

    property p_two_flops;
      !$past(rst) |=> (s_q.raw_s2[j] == $past(cmp_raw[j], 2));
    endproperty
    a_two_flops: assert property (p_two_flops) else $error("raw sync depth wrong");
  end

  c_flag_set:   cover property (!cmp_irq_flag[0] ##1 cmp_irq_flag[0]);
  c_sync_mode:  cover property (s_q.ctrl0[1][B_SYNC] && tclk_fall);
  c_hold_block: cover property (s_q.ctrl0[0][B_HOLD] && s_q.hold_cnt[0] != 4'h0
                                && s_q.pol_q[0] != s_q.result[0]);
endmodule // cmp_ctrl

// *** cmp_src_model.sv ***
// Partner model: the two analog comparator cores and the gate timer clocks.
// Assumes the bench asks for levels; each level lands just after sys_clk rises.
module cmp_src_model (
  input  wire logic       sys_clk,
  input  wire logic [1:0] raw_req,
  input  wire logic       src_req,
  input  wire logic       pre_req,
  output logic      [1:0] cmp_raw,
  output logic            tmr_src_clk,
  output logic            tmr_pre_clk
);
  // ----------------------------------------------------------------
  // Analog results and timer clocks
  // ----------------------------------------------------------------
  // Timer clocks stand still unless asked to move, so a latch edge is explicit
  always_ff @(posedge sys_clk) begin
    cmp_raw     <= raw_req;
    tmr_src_clk <= src_req;
    tmr_pre_clk <= pre_req;
  end
endmodule // cmp_src_model

// *** test_comparator_control_logic.sv ***
// Self-checking bench for the comparator control block.
// Assumes cmp_ctrl with two comparators and the partner model beside it.
module test_comparator_control_logic;
  import cmp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic [4:0]        avs_address = 5'h00;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = 32'h0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic [1:0]        raw_req = 2'h0;
  logic              src_req = 1'b1;
  logic              pre_req = 1'b1;
  logic              tmr_prescale_en = 1'b0;
  logic [7:0]        pin_level = 8'h00;
  logic [1:0]        cmp_raw;
  logic              tmr_src_clk;
  logic              tmr_pre_clk;
  logic [1:0]        gate_out;
  logic              gate_timer_tick;
  logic [1:0]        cmp_irq_flag;
  analog_ctl_t [1:0] analog_ctl;
  int                err_total = 0;
  int                compares = 0;
  int                cyc = 0;

  cmp_src_model i_src (.sys_clk(sys_clk), .raw_req(raw_req), .src_req(src_req),
    .pre_req(pre_req), .cmp_raw(cmp_raw), .tmr_src_clk(tmr_src_clk),
    .tmr_pre_clk(tmr_pre_clk));
  cmp_ctrl #(.NUM_CMP(2)) i_dut (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmp_raw(cmp_raw), .tmr_src_clk(tmr_src_clk), .tmr_pre_clk(tmr_pre_clk),
    .tmr_prescale_en(tmr_prescale_en), .pin_level(pin_level), .gate_out(gate_out),
    .gate_timer_tick(gate_timer_tick), .cmp_irq_flag(cmp_irq_flag),
    .analog_ctl(analog_ctl));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  always #10 sys_clk = ~sys_clk;
  // The whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One Avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    if (!wr) chk(avs_readdata[31:8], 32'h0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    logic [31:0] got;
    bus(1'b0, a, 8'h00);
    got = avs_readdata;
    chk(got, {24'h0, exp});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk(OFS_CTRL0_C1, 8'h04);
    rdchk(OFS_CTRL1_C2, 8'h00);
    rdchk(OFS_MIRROR, 8'h00);
    chk(analog_ctl[0], 9'h002);
  endtask
  task automatic t_fields();
    bus(1'b1, OFS_CTRL0_C2, 8'hff);
    step(10);
    rdchk(OFS_CTRL0_C2, 8'hdf);
    chk(analog_ctl[1], 9'h103);
    bus(1'b1, OFS_CTRL0_C2, 8'h00);
    step(10);
    rdchk(OFS_CTRL0_C2, 8'h00);
    chk(analog_ctl[1], 9'h000);
  endtask
  task automatic t_select();
    logic [2:0] s;
    bus(1'b1, OFS_CTRL0_C1, 8'h84);
    for (int i = 0; i < 8; i++) begin
      s = i[2:0];
      bus(1'b1, OFS_CTRL1_C1, {2'b00, s, ~s});
      step(2);
      chk(analog_ctl[0], {1'b1, s, ~s, 2'b10});
    end
    bus(1'b1, OFS_CTRL0_C1, 8'h04);
    step(2);
    chk(analog_ctl[0].connect, 1'b0);
  endtask
  task automatic t_edges();
    bus(1'b1, OFS_CTRL1_C1, 8'h80);
    bus(1'b1, OFS_CTRL0_C1, 8'h84);
    bus(1'b1, OFS_FLAGS, 8'h03);
    raw_req <= 2'b01;
    step(10);
    chk(cmp_irq_flag, 2'b01);
    rdchk(OFS_MIRROR, 8'h01);
    bus(1'b1, OFS_FLAGS, 8'h01);
    raw_req <= 2'b00;
    step(10);
    chk(cmp_irq_flag, 2'b00);
    bus(1'b1, OFS_CTRL1_C1, 8'h40);
    raw_req <= 2'b01;
    step(10);
    chk(cmp_irq_flag, 2'b00);
    raw_req <= 2'b00;
    step(10);
    chk(cmp_irq_flag, 2'b01);
    bus(1'b1, OFS_CTRL1_C1, 8'h80);
    bus(1'b1, OFS_CTRL0_C1, 8'h04);
    bus(1'b1, OFS_FLAGS, 8'h01);
    step(10);
    bus(1'b1, OFS_CTRL0_C1, 8'h14);
    step(10);
    chk(cmp_irq_flag, 2'b01);
    bus(1'b1, OFS_FLAGS, 8'h01);
  endtask
  task automatic t_port();
    pin_level <= 8'ha5;
    rdchk(OFS_PORT, 8'h00);
    bus(1'b1, OFS_ANALOG_SELECT_REG, 8'h0f);
    rdchk(OFS_PORT, 8'ha0);
  endtask
  // Raw result toggles every cycle; the hold must stop back-to-back reversals
  task automatic t_hold();
    int   flips;
    int   pairs;
    logic last;
    logic moved;
    for (int pass = 0; pass < 2; pass++) begin
      bus(1'b1, OFS_CTRL0_C1, (pass == 0) ? 8'h8c : 8'h84);
      step(10);
      flips = 0;
      pairs = 0;
      moved = 1'b0;
      last = gate_out[0];
      for (int i = 0; i < 16; i++) begin
        raw_req <= {1'b0, ~raw_req[0]};
        step(1);
        if (gate_out[0] !== last) begin
          flips++;
          if (moved) pairs++;
        end
        moved = (gate_out[0] !== last);
        last = gate_out[0];
      end
      if (pass == 0) begin
        chk(pairs, 0);
        chk(flips > 2, 1);
      end else begin
        chk(pairs > 2, 1);
      end
    end
    raw_req <= 2'b00;
    step(10);
  endtask
  task automatic t_sync();
    int n;
    n = 0;
    bus(1'b1, OFS_CTRL1_C1, 8'h00);
    bus(1'b1, OFS_CTRL0_C1, 8'h84);
    raw_req <= 2'b01;
    step(10);
    chk(gate_out, 2'b01);
    raw_req <= 2'b00;
    step(10);
    chk(gate_out[0], 1'b0);
    bus(1'b1, OFS_CTRL0_C1, 8'h85);
    raw_req <= 2'b01;
    step(10);
    chk(gate_out[0], 1'b0);
    src_req <= 1'b0;
    step(10);
    chk(gate_out[0], 1'b1);
    src_req <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      step(1);
      if (gate_timer_tick === 1'b1) n++;
    end
    chk(n, 1);
    tmr_prescale_en <= 1'b1;
    raw_req <= 2'b00;
    step(10);
    src_req <= 1'b0;
    step(10);
    chk(gate_out[0], 1'b1);
    pre_req <= 1'b0;
    step(10);
    chk(gate_out[0], 1'b0);
  endtask

  initial begin
    step(4);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_select();
    t_edges();
    t_port();
    t_hold();
    t_sync();
    final_report();
  end
endmodule // test_comparator_control_logic
